// file: rtl/tmr_pwm_pkg.sv
// Purpose: shared constants and types for the two-timer modulator and tone block
// Assumes: classic wishbone slave, 32-bit data, registers in the low byte of each word
// Notes: counter widths per timer are fixed at build time
package tmr_pwm_pkg;
    // register byte offsets
    localparam logic [4:0] first_mode_off = 5'h00;
    localparam logic [4:0] first_count_off = 5'h04;
    localparam logic [4:0] first_duty_off = 5'h08;
    localparam logic [4:0] second_mode_off = 5'h0c;
    localparam logic [4:0] second_count_off = 5'h10;
    localparam logic [4:0] second_duty_off = 5'h14;
    localparam logic [4:0] status_off = 5'h18;
    // mode register field positions
    localparam int mode_enable_bit = 7;
    localparam int mode_rate_lsb = 4;
    localparam int mode_fast_bit = 3;
    localparam int mode_pwm_bit = 2;
    localparam int mode_tone_bit = 1;
    localparam int mode_reload_bit = 0;
    // status register field positions
    localparam int stat_first_req_bit = 0;
    localparam int stat_second_req_bit = 1;
    localparam int stat_first_ien_bit = 4;
    localparam int stat_second_ien_bit = 5;
    // values after reset
    localparam logic [7:0] mode_reset = 8'h00;
    localparam logic [7:0] count_reset = 8'h00;
    localparam logic [7:0] duty_reset = 8'h00;
    // counter width options
    localparam int width_8 = 8;
    localparam int width_6 = 6;
    localparam int width_5 = 5;
    localparam int width_4 = 4;
    // prescaler: slow divides by 2^(10-rate), fast by 2^(7-rate)
    localparam int pre_w = 10;
    localparam logic [3:0] slow_exp = 4'ha;
    localparam logic [3:0] fast_exp = 4'h7;

    typedef struct packed {
        logic enable;
        logic [2:0] rate;
        logic fast;
        logic pwm_en;
        logic tone_en;
        logic reload_en;
    } timer_ctrl_t;
endpackage : tmr_pwm_pkg

// file: rtl/tmr_pwm_top.sv
// Purpose: two timer counters with modulated outputs, tone output on the second
// Assumes: clk_i is the oscillator clock, rst_i synchronous active high
// Notes: duty references are write-only and read back as zero
`timescale 1ns/100ps

module timer_channel
    import tmr_pwm_pkg::*;
#(
    parameter int width = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire timer_ctrl_t ctrl_i,
    input wire logic [7:0] reload_i,
    input wire logic [7:0] duty_i,
    input wire logic count_wr_i,
    input wire logic [7:0] count_wdata_i,
    // results
    output logic [7:0] count_o,
    output logic overflow_o,
    output logic pwm_o,
    output logic tone_o
);
    logic [pre_w-1:0] pre_reg;
    logic [pre_w-1:0] pre_mask;
    logic [3:0] pre_exp;
    logic tick;
    logic [width-1:0] count_reg;
    logic [width-1:0] count_next;
    logic [width-1:0] duty_low;
    logic wrap;
    logic pwm_reg;
    logic tone_reg;

    // clock selection from rate field and fast select
    always_comb begin
        pre_exp = (ctrl_i.fast ? fast_exp : slow_exp) - {1'b0, ctrl_i.rate}; // R11 R12
        pre_mask = pre_w'((11'h001 << pre_exp) - 11'h001);
        tick = ctrl_i.enable && ((pre_reg & pre_mask) == pre_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl_i.enable) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 1'b1;
        end
    end

    // wrap when all counter bits are ones at a tick
    assign wrap = tick && (&count_reg); // R3 R13 R14 R15 R16 R17 R22
    assign duty_low = duty_i[width-1:0]; // R23 R7

    always_comb begin
        count_next = count_reg;
        if (count_wr_i) begin
            count_next = count_wdata_i[width-1:0];
        end else if (wrap) begin
            count_next = ctrl_i.reload_en ? reload_i[width-1:0] : '0; // R19
        end else if (tick) begin
            count_next = count_reg + 1'b1; // R21
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= count_reset[width-1:0];
        end else begin
            count_reg <= count_next;
        end
    end

    // modulated output: high at wrap unless the reference is zero, low on match, starts low
    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl_i.pwm_en) begin
            pwm_reg <= 1'b0; // R6
        end else if (wrap) begin
            pwm_reg <= (duty_low != '0); // R5 R9
        end else if (count_next == duty_low) begin
            pwm_reg <= 1'b0; // R4
        end
    end

    // tone toggles on each overflow
    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl_i.tone_en) begin
            tone_reg <= 1'b0;
        end else if (wrap) begin
            tone_reg <= !tone_reg; // R2
        end
    end

    assign count_o = 8'(count_reg);
    assign overflow_o = wrap;
    assign pwm_o = pwm_reg;
    assign tone_o = tone_reg;
endmodule : timer_channel

// Behaviour
// R1: tone enable takes over shared pin from gpio
// R2: tone output is overflow rate halved
// R3: 8-bit counter counts 0 to 255
// R4: counter equals reference drives output low
// R5: counter wrap forces output high
// R6: output low until first wrap after enable
// R7: duty set by reference in single counts
// R8: duty reference reads back as zero
// R9: reference zero holds output low
// R10: software rewrites reference to change duty
// R11: slow clock divides by two^(10-rate)
// R12: fast clock divides by two^(7-rate)
// R13: modulus follows width option 256/64/32/16
// R14: 6-bit overflow from 3fh
// R15: 5-bit overflow from 1fh
// R16: 4-bit overflow from 0fh
// R17: 8-bit overflow from ffh to 00h
// R18: each timer drives its own pin
// R19: reload copies into counter on overflow
// R20: overflow sets request, software clears it
// R21: counter increments on each selected clock
// R22: width option is a build parameter
// R23: compare uses low width bits only
module tmr_pwm_top
    import tmr_pwm_pkg::*;
#(
    parameter int first_width_option = width_8,
    parameter int second_width_option = width_8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // general purpose drive of the two shared pins
    input wire logic first_pin_gpio_i,
    input wire logic second_pin_gpio_i,
    // pins
    output logic first_modulated_output_o,
    output logic second_modulated_output_o,
    output logic first_pin_gpio_disabled_o,
    output logic second_pin_gpio_disabled_o,
    // overflow requests and their enables
    output logic first_overflow_request_o,
    output logic second_overflow_request_o,
    output logic first_overflow_irq_enable_o,
    output logic second_overflow_irq_enable_o
);
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wr_take;
    logic [7:0] first_mode_reg;
    logic [7:0] second_timer_mode_reg;
    logic [7:0] first_duty_reference_reg;
    logic [7:0] second_duty_reference_reg;
    logic first_req_reg;
    logic second_overflow_request_reg;
    logic first_ien_reg;
    logic second_overflow_irq_enable_reg;
    logic first_pin_reg;
    logic second_pin_reg;
    timer_ctrl_t first_ctrl;
    timer_ctrl_t second_ctrl;
    logic [7:0] first_count_value;
    logic [7:0] second_count_value;
    logic first_ovf;
    logic second_ovf;
    logic first_pwm;
    logic second_pwm;
    logic second_tone;
    logic first_count_wr;
    logic second_count_wr;

    // write takes effect on the edge where ack is seen
    assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
    assign first_count_wr = wr_take && (wb_adr_i == first_count_off);
    assign second_count_wr = wr_take && (wb_adr_i == second_count_off);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
        end
    end

    // read mux, unmapped reads return zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (wb_adr_i == first_mode_off) begin
            rdata_next[7:0] = first_mode_reg;
        end else if (wb_adr_i == first_count_off) begin
            rdata_next[7:0] = first_count_value;
        end else if (wb_adr_i == second_mode_off) begin
            rdata_next[7:0] = second_timer_mode_reg;
        end else if (wb_adr_i == second_count_off) begin
            rdata_next[7:0] = second_count_value;
        end else if (wb_adr_i == status_off) begin
            rdata_next[stat_first_req_bit] = first_req_reg;
            rdata_next[stat_second_req_bit] = second_overflow_request_reg;
            rdata_next[stat_first_ien_bit] = first_ien_reg;
            rdata_next[stat_second_ien_bit] = second_overflow_irq_enable_reg;
        end
        // duty references stay at zero on read R8
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
            rdata_reg <= rdata_next;
        end
    end

    // control and duty registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_mode_reg <= mode_reset;
            second_timer_mode_reg <= mode_reset;
            first_duty_reference_reg <= duty_reset;
            second_duty_reference_reg <= duty_reset;
            first_ien_reg <= 1'b0;
            second_overflow_irq_enable_reg <= 1'b0;
        end else if (wr_take) begin
            if (wb_adr_i == first_mode_off) begin
                first_mode_reg <= wb_dat_i[7:0];
            end else if (wb_adr_i == first_duty_off) begin
                first_duty_reference_reg <= wb_dat_i[7:0]; // R10
            end else if (wb_adr_i == second_mode_off) begin
                second_timer_mode_reg <= wb_dat_i[7:0];
            end else if (wb_adr_i == second_duty_off) begin
                second_duty_reference_reg <= wb_dat_i[7:0]; // R10
            end else if (wb_adr_i == status_off) begin
                first_ien_reg <= wb_dat_i[stat_first_ien_bit];
                second_overflow_irq_enable_reg <= wb_dat_i[stat_second_ien_bit];
            end
        end
    end

    // overflow requests: set wins over write-one-to-clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_req_reg <= 1'b0;
            second_overflow_request_reg <= 1'b0;
        end else begin
            if (first_ovf) begin
                first_req_reg <= 1'b1; // R20
            end else if (wr_take && (wb_adr_i == status_off) && wb_dat_i[stat_first_req_bit]) begin
                first_req_reg <= 1'b0;
            end
            if (second_ovf) begin
                second_overflow_request_reg <= 1'b1; // R20
            end else if (wr_take && (wb_adr_i == status_off) && wb_dat_i[stat_second_req_bit]) begin
                second_overflow_request_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        first_ctrl.enable = first_mode_reg[mode_enable_bit];
        first_ctrl.rate = first_mode_reg[mode_rate_lsb +: 3];
        first_ctrl.fast = first_mode_reg[mode_fast_bit];
        first_ctrl.pwm_en = first_mode_reg[mode_pwm_bit];
        first_ctrl.tone_en = 1'b0;
        first_ctrl.reload_en = first_mode_reg[mode_reload_bit];
        second_ctrl.enable = second_timer_mode_reg[mode_enable_bit];
        second_ctrl.rate = second_timer_mode_reg[mode_rate_lsb +: 3];
        second_ctrl.fast = second_timer_mode_reg[mode_fast_bit];
        second_ctrl.pwm_en = second_timer_mode_reg[mode_pwm_bit];
        second_ctrl.tone_en = second_timer_mode_reg[mode_tone_bit];
        second_ctrl.reload_en = second_timer_mode_reg[mode_reload_bit];
    end

    timer_channel #(
        .width(first_width_option)
    ) u_first (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ctrl_i(first_ctrl),
        .reload_i(first_duty_reference_reg),
        .duty_i(first_duty_reference_reg),
        .count_wr_i(first_count_wr),
        .count_wdata_i(wb_dat_i[7:0]),
        .count_o(first_count_value),
        .overflow_o(first_ovf),
        .pwm_o(first_pwm),
        .tone_o()
    );

    timer_channel #(
        .width(second_width_option)
    ) u_second (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ctrl_i(second_ctrl),
        .reload_i(second_duty_reference_reg),
        .duty_i(second_duty_reference_reg),
        .count_wr_i(second_count_wr),
        .count_wdata_i(wb_dat_i[7:0]),
        .count_o(second_count_value),
        .overflow_o(second_ovf),
        .pwm_o(second_pwm),
        .tone_o(second_tone)
    );

    // pin muxes: each timer to its own pin, tone first on the second pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_pin_reg <= 1'b0;
            second_pin_reg <= 1'b0;
        end else begin
            first_pin_reg <= first_ctrl.pwm_en ? first_pwm : first_pin_gpio_i; // R18
            if (second_ctrl.tone_en) begin
                second_pin_reg <= second_tone; // R1
            end else if (second_ctrl.pwm_en) begin
                second_pin_reg <= second_pwm; // R18
            end else begin
                second_pin_reg <= second_pin_gpio_i;
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign first_modulated_output_o = first_pin_reg;
    assign second_modulated_output_o = second_pin_reg;
    assign first_pin_gpio_disabled_o = first_ctrl.pwm_en;
    assign second_pin_gpio_disabled_o = second_ctrl.tone_en || second_ctrl.pwm_en; // R1
    assign first_overflow_request_o = first_req_reg;
    assign second_overflow_request_o = second_overflow_request_reg;
    assign first_overflow_irq_enable_o = first_ien_reg;
    assign second_overflow_irq_enable_o = second_overflow_irq_enable_reg;
endmodule : tmr_pwm_top

// file: dv/tmr_pwm_props.sv
// Purpose: bus and pin checks for the timer block
// Assumes: one clock, synchronous reset
// Notes: mode bytes are mirrored from bus writes
`timescale 1ns/100ps
module tmr_pwm_props
    import tmr_pwm_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // pins and flags
    input wire logic first_pin_gpio_i,
    input wire logic first_modulated_output_o,
    input wire logic first_pin_gpio_disabled_o,
    input wire logic second_pin_gpio_disabled_o,
    input wire logic first_overflow_request_o,
    input wire logic first_overflow_irq_enable_o,
    input wire logic second_overflow_irq_enable_o
);
    logic wr_ok;
    logic clr_first;
    logic [7:0] m1_reg;
    logic [7:0] m2_reg;
    assign wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0];
    assign clr_first = wr_ok && wb_adr_i == status_off && wb_dat_i[stat_first_req_bit];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            m1_reg <= 8'h00;
            m2_reg <= 8'h00;
        end else if (wr_ok && wb_adr_i == first_mode_off) begin
            m1_reg <= wb_dat_i[7:0];
        end else if (wr_ok && wb_adr_i == second_mode_off) begin
            m2_reg <= wb_dat_i[7:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_ack_after_req: assert property (s_req |=> wb_ack_o) else $error("no ack after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
    a_duty_reads_zero: assert property (
        s_req ##0 (!wb_we_i && (wb_adr_i == first_duty_off || wb_adr_i == second_duty_off)) |=> wb_dat_o == 32'h0)
        else $error("duty reference readable");
    a_first_owner: assert property (
        first_pin_gpio_disabled_o == m1_reg[mode_pwm_bit]) else $error("first pin owner wrong");
    a_second_owner: assert property (
        second_pin_gpio_disabled_o == (m2_reg[mode_tone_bit] || m2_reg[mode_pwm_bit])) else $error("second pin owner");
    a_gpio_pin: assert property (
        !rst_i && !first_pin_gpio_disabled_o |=> first_modulated_output_o == $past(first_pin_gpio_i))
        else $error("first pin not gpio");
    a_pwm_start_low: assert property ($rose(first_pin_gpio_disabled_o) |=> !first_modulated_output_o)
        else $error("pwm high at enable");
    a_req_sticky: assert property (
        first_overflow_request_o && !clr_first |=> first_overflow_request_o) else $error("request lost");
    a_irq_en_write: assert property (wr_ok && wb_adr_i == status_off |=>
        first_overflow_irq_enable_o == $past(wb_dat_i[stat_first_ien_bit]) &&
        second_overflow_irq_enable_o == $past(wb_dat_i[stat_second_ien_bit])) else $error("irq enable write");
endmodule : tmr_pwm_props

bind tmr_pwm_top tmr_pwm_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .first_pin_gpio_i(first_pin_gpio_i),
    .first_modulated_output_o(first_modulated_output_o), .first_pin_gpio_disabled_o(first_pin_gpio_disabled_o),
    .second_pin_gpio_disabled_o(second_pin_gpio_disabled_o), .first_overflow_request_o(first_overflow_request_o),
    .first_overflow_irq_enable_o(first_overflow_irq_enable_o),
    .second_overflow_irq_enable_o(second_overflow_irq_enable_o));

// file: dv/buzzer_load.sv
// Purpose: buzzer load on the second pin
// Assumes: pin sampled on the block clock
// Notes: reports cycles between rising edges
`timescale 1ns/100ps
module buzzer_load (
    // pin side
    input wire logic clk_i,
    input wire logic pin_i,
    // measurement
    output logic [15:0] period_o
);
    logic last_reg;
    logic [15:0] gap_reg;
    always_ff @(posedge clk_i) begin
        last_reg <= pin_i;
        gap_reg <= (pin_i && !last_reg) ? 16'h1 : gap_reg + 16'h1;
        if (pin_i && !last_reg) begin
            period_o <= gap_reg;
        end
    end
endmodule : buzzer_load

// file: dv/tb.sv
// Purpose: bench for the two-timer modulator block
// Assumes: 250 MHz clock, widths 8 and 4
// Notes: seeded xorshift drives duty and gpio
`timescale 1ns/100ps
module tb
    import tmr_pwm_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [4:0] adr = 5'h00;
    logic [31:0] dat_w = 32'h0, dat_r, seed = 32'h10;
    logic [1:0] gpio = 2'b00, pin;
    logic [1:0] req;
    logic [15:0] period;
    logic [7:0] tmode [4] = '{8'hfa, 8'hea, 8'hf2, 8'hfb};
    int n_fail = 0, compares = 0;
    always #2 clk_i = ~clk_i;
    function automatic logic [31:0] rnd(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : rnd
    // tone period of the 4-bit second timer: two overflows of selected clock ticks
    function automatic logic [31:0] tone_period(input logic [7:0] m, input logic [7:0] r);
        logic [3:0] e;
        logic [31:0] c;
        e = (m[mode_fast_bit] ? fast_exp : slow_exp) - {1'b0, m[mode_rate_lsb +: 3]};
        c = 32'(1 << width_4);
        if (m[mode_reload_bit]) begin
            c = c - {28'h0, r[3:0]};
        end
        return (c << e) << 1;
    endfunction : tone_period
    always @(posedge clk_i) begin
        seed <= rnd(seed);
        gpio <= seed[1:0];
    end
    tmr_pwm_top #(.first_width_option(width_8), .second_width_option(width_4)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .first_pin_gpio_i(gpio[0]), .second_pin_gpio_i(gpio[1]),
        .first_modulated_output_o(pin[0]), .second_modulated_output_o(pin[1]),
        .first_pin_gpio_disabled_o(), .second_pin_gpio_disabled_o(),
        .first_overflow_request_o(req[0]), .second_overflow_request_o(req[1]),
        .first_overflow_irq_enable_o(), .second_overflow_irq_enable_o());
    buzzer_load u_load (.clk_i(clk_i), .pin_i(pin[1]), .period_o(period));
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_pin(input logic v, input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pin[0] !== v && n < lim);
    endtask : wait_pin
    task automatic conclude;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        #120000;
        n_fail++;
        conclude();
    end
    initial begin
        logic [31:0] q;
        logic [7:0] d;
        int n;
        int h;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a < 32; a += 4) begin
            wb(1'b0, 5'(a), 32'h0, q);
            chk(q, 32'h0);
        end
        wb(1'b1, first_count_off, 32'hf0, q);
        wb(1'b1, first_mode_off, 32'hf8, q);
        wb(1'b0, status_off, 32'h0, q);
        chk(q, 32'h0);
        repeat (16) @(posedge clk_i);
        wb(1'b0, status_off, 32'h0, q);
        chk(q, 32'h1);
        wb(1'b1, status_off, 32'h31, q);
        wb(1'b0, status_off, 32'h0, q);
        chk(q, 32'h30);
        chk({31'h0, req[0]}, 32'h0);
        wb(1'b1, first_mode_off, 32'h0, q);
        wb(1'b1, first_count_off, 32'h0, q);
        wb(1'b1, first_duty_off, 32'h1, q);
        wb(1'b1, first_mode_off, 32'hfc, q);
        wait_pin(1'b1, 600, n);
        chk(32'(n >= 250 && n < 300), 32'h1);
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 8'h01 : (i == 1) ? 8'hff : (i == 4) ? 8'h00 : seed[7:0];
            wb(1'b1, first_duty_off, {24'h0, d}, q);
            wait_pin(1'b0, 600, n);
            wait_pin(1'b1, 600, n);
            h = 0;
            repeat (256) begin
                h += int'(pin[0] === 1'b1);
                @(posedge clk_i);
            end
            chk(32'(h), {24'h0, d});
        end
        wb(1'b1, first_mode_off, 32'h0, q);
        wb(1'b1, second_duty_off, 32'h8, q);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, second_mode_off, {24'h0, tmode[i]}, q);
            repeat (800) @(posedge clk_i);
            chk({16'h0, period}, tone_period(tmode[i], 8'h08));
        end
        wb(1'b0, status_off, 32'h0, q);
        chk(q, 32'h33);
        chk({30'h0, req}, 32'h3);
        conclude();
    end
endmodule : tb
